//--- rtl/iit_pkg.sv
// How it works
// RULE_01 - After an interrupt condition is sensed, at least three clock periods and two parcel issues pass before the interrupt is raised.
// RULE_02 - During the first three clock periods after sensing, parcels keep issuing whenever no hold-issue condition is present.
// RULE_03 - At the end of those three periods the next-parcel register is inspected, and a two-parcel instruction there means three parcel issues before the interrupt.
// RULE_04 - A one-parcel instruction in the next-parcel register means only two parcel issues before the interrupt.
// RULE_05 - No interrupt is ever raised while the CPU is in monitor mode.
// RULE_06 - A floating-point range error raises an interrupt only with the floating-point mode flag set and monitor mode off.
// RULE_07 - The disable-floating-interrupt instruction clears the floating-point mode flag.
// RULE_08 - The enable-floating-interrupt instruction sets the floating-point mode flag.
// RULE_09 - Privileged monitor instructions are allowed to execute only in monitor mode.
// RULE_10 - All timing runs from one synchronous clock whose period is 12.5 ns.
// RULE_11 - During deadstart the external controller loads a program with an exchange package at address zero.
// RULE_12 - After loading, the controller sends a start signal and the CPU then begins executing the program.
// RULE_13 - A two-parcel instruction takes two clock periods to issue.
// RULE_14 - A sensed interrupt condition stays pending until the interrupt is raised or monitor mode releases it.
package iit_pkg;

	localparam int SENSE_WAIT_CP  = 3;
	localparam int ISSUE_LONG_N   = 3;
	localparam int ISSUE_SHORT_N  = 2;
	localparam int TWO_PARCEL_CP  = 2;
	localparam int CLK_PERIOD_PS  = 12500;
	localparam logic [2:0] CNT_ZERO = 3'h0;

	typedef enum logic [2:0] {
		IIT_IDLE,
		IIT_LOAD,
		IIT_WAIT,
		IIT_COUNT
	} iit_state_e;

	// Decoded view of the instruction sitting in the next-parcel register.
	typedef struct packed {
		logic valid;
		logic two_parcel;
		logic efi;
		logic dfi;
		logic privileged;
	} iit_parcel_s;

endpackage : iit_pkg

//--- rtl/iit_top.sv
`timescale 1ns/1ns
module iit_top
	import iit_pkg::*;
#(
	parameter int WAIT_CP = SENSE_WAIT_CP
) (
	// Clock and reset.
	input  wire logic        MCLK,
	input  wire logic        RST_B,
	// Deadstart handshake with the external controller.
	input  wire logic        DS_START,
	// Instruction stream.
	input  wire iit_parcel_s NEXT_PARCEL,
	input  wire logic        HOLD_ISSUE,
	input  wire logic        MONITOR_MODE,
	// Event sources.
	input  wire logic        INT_COND,
	input  wire logic        FP_RANGE_ERR,
	// Results.
	output logic             RUNNING,
	output logic             PARCEL_ISSUE,
	output logic             INSTR_EXEC,
	output logic             PRIV_VIOLATION,
	output logic             FP_MODE,
	output logic             INT_PEND,
	output logic             INTERRUPT
);

	// The wait counter is three bits wide, so longer waits cannot be served.
	if (WAIT_CP < 1 || WAIT_CP > 7) begin : g_bad_wait_cp
		$error("WAIT_CP out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	logic       run_q;
	logic       half_q;
	logic       issue_now;
	logic       exec_now;
	logic       fp_q;
	logic       pend_q;
	logic       int_q;
	iit_state_e st_q;
	logic [2:0] cp_q;
	logic [2:0] left_q;
	logic       sense;

	// Deadstart: nothing issues until the controller says the program is loaded.
	always_ff @(posedge MCLK or negedge RST_B) begin // RULE_10
		if (!RST_B) begin
			run_q <= 1'b0;
		end else if (DS_START) begin
			run_q <= 1'b1; // RULE_12
		end
	end

	// A two-parcel instruction spends a first clock on its leading parcel.
	assign issue_now = run_q && NEXT_PARCEL.valid && !HOLD_ISSUE && !int_q; // RULE_02
	assign exec_now  = issue_now && (!NEXT_PARCEL.two_parcel || half_q); // RULE_13

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			half_q <= 1'b0;
		end else if (issue_now && NEXT_PARCEL.two_parcel) begin
			half_q <= !half_q; // RULE_13
		end
	end

	// Privileged opcodes outside monitor mode are refused, not executed.
	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			INSTR_EXEC     <= 1'b0;
			PRIV_VIOLATION <= 1'b0;
		end else begin
			INSTR_EXEC     <= exec_now && (!NEXT_PARCEL.privileged || MONITOR_MODE); // RULE_09
			PRIV_VIOLATION <= exec_now && NEXT_PARCEL.privileged && !MONITOR_MODE; // RULE_09
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			fp_q <= 1'b1;
		end else if (exec_now && NEXT_PARCEL.dfi) begin
			fp_q <= 1'b0; // RULE_07
		end else if (exec_now && NEXT_PARCEL.efi) begin
			fp_q <= 1'b1; // RULE_08
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Monitor mode masks sensing entirely, so a condition never lingers into user code.
	assign sense = !MONITOR_MODE && (INT_COND || (FP_RANGE_ERR && fp_q)); // RULE_05 RULE_06

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			pend_q <= 1'b0;
		end else if (sense) begin
			// A condition sensed in the interrupt cycle opens a new round, so the set wins.
			pend_q <= 1'b1; // RULE_14
		end else if (MONITOR_MODE || int_q) begin
			pend_q <= 1'b0; // RULE_14
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q   <= IIT_IDLE;
			cp_q   <= CNT_ZERO;
			left_q <= CNT_ZERO;
			int_q  <= 1'b0;
		end else begin
			int_q <= 1'b0;
			case (st_q)
				IIT_IDLE: begin
					if (sense) begin
						st_q <= IIT_WAIT;
						cp_q <= 3'(WAIT_CP - 1); // RULE_01
					end
				end
				IIT_WAIT: begin
					if (MONITOR_MODE) begin
						st_q <= IIT_IDLE;
					end else if (cp_q == CNT_ZERO) begin
						st_q <= IIT_COUNT;
						if (NEXT_PARCEL.two_parcel) begin
							left_q <= 3'(ISSUE_LONG_N); // RULE_03
						end else begin
							left_q <= 3'(ISSUE_SHORT_N); // RULE_04
						end
					end else begin
						cp_q <= cp_q - 3'h1;
					end
				end
				IIT_COUNT: begin
					if (MONITOR_MODE) begin
						st_q <= IIT_IDLE; // RULE_05
					end else if (issue_now && left_q == 3'h1) begin
						st_q  <= IIT_IDLE;
						int_q <= 1'b1; // RULE_01
					end else if (issue_now) begin
						left_q <= left_q - 3'h1;
					end
				end
				default: begin
					st_q <= IIT_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge RST_B) begin
		if (!RST_B) begin
			RUNNING      <= 1'b0;
			PARCEL_ISSUE <= 1'b0;
			FP_MODE      <= 1'b1;
			INT_PEND     <= 1'b0;
			INTERRUPT    <= 1'b0;
		end else begin
			RUNNING      <= run_q;
			PARCEL_ISSUE <= issue_now;
			FP_MODE      <= fp_q;
			INT_PEND     <= pend_q;
			INTERRUPT    <= int_q && !MONITOR_MODE; // RULE_05
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	sequence s_sensed;
		st_q == IIT_IDLE && sense;
	endsequence

	sequence s_last_issue;
		st_q == IIT_COUNT && !MONITOR_MODE && issue_now && left_q == 3'h1;
	endsequence

	a_pend_set: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_14
		sense |=> pend_q)
		else $error("sensed condition not latched as pending");

	a_last_issue_int: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_01
		s_last_issue |=> int_q)
		else $error("last counted issue did not raise the interrupt");

	a_int_drive: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_01
		int_q && !MONITOR_MODE |=> INTERRUPT)
		else $error("internal interrupt not driven out");

	a_wait_min_cps: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_01
		s_sensed |=> !int_q [*3])
		else $error("interrupt raised before three clock periods");

	a_no_mon_int: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_05
		MONITOR_MODE |=> !INTERRUPT)
		else $error("interrupt raised in monitor mode");

	a_short_count: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_04
		st_q == IIT_WAIT && cp_q == CNT_ZERO && !MONITOR_MODE && !NEXT_PARCEL.two_parcel
		|=> left_q == 3'h2)
		else $error("one-parcel case not loading two issues");

	a_long_count: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_03
		st_q == IIT_WAIT && cp_q == CNT_ZERO && !MONITOR_MODE && NEXT_PARCEL.two_parcel
		|=> left_q == 3'h3)
		else $error("two-parcel case not loading three issues");

	a_fp_disable: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_07
		exec_now && NEXT_PARCEL.dfi |=> !fp_q)
		else $error("disable instruction left flag set");

	a_fp_enable: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_08
		exec_now && NEXT_PARCEL.efi && !NEXT_PARCEL.dfi |=> fp_q)
		else $error("enable instruction left flag clear");

	a_fp_gate: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_06
		FP_RANGE_ERR && !INT_COND && (!fp_q || MONITOR_MODE) |-> !sense)
		else $error("gated range error was sensed");

	a_priv_block: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_09
		exec_now && NEXT_PARCEL.privileged && !MONITOR_MODE |=> !INSTR_EXEC && PRIV_VIOLATION)
		else $error("privileged instruction ran outside monitor mode");

	a_no_issue_prestart: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_12
		!run_q |-> !issue_now)
		else $error("issue before deadstart start");

	a_two_cp_issue: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_13
		issue_now && NEXT_PARCEL.two_parcel && !half_q |-> !exec_now)
		else $error("two-parcel instruction finished in one clock");

	a_pend_hold: assert property (@(posedge MCLK) disable iff (!RST_B) // RULE_14
		pend_q && !int_q && !MONITOR_MODE |=> pend_q)
		else $error("pending condition dropped early");

endmodule : iit_top

//--- tb/iit_ctrl_model.sv
`timescale 1ns/1ns
module iit_ctrl_model #(
	parameter int LOAD_CP = 4
) (
	input  wire logic clk,
	input  wire logic rst_b,
	output logic      start
);
	// Only the length of the program load is modelled, not the memory image.
	int cnt;
	// Counting on the rising edge keeps clear of the falling edge where reset is let go.
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 0;
		end else if (cnt < LOAD_CP) begin
			cnt <= cnt + 1;
		end
	end
	// Start stays high once given, since the block accepts a level.
	assign start = (cnt == LOAD_CP);
endmodule : iit_ctrl_model

//--- tb/tb_iit_top.sv
`timescale 1ns/1ns
module tb_iit_top;
	import iit_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_b = 1'b0;
	logic        ds;
	iit_parcel_s np = 5'h10;
	logic        hold = 1'b0;
	logic        mon = 1'b0;
	logic        ic = 1'b0;
	logic        fe = 1'b0;
	logic        run, iss, ex, pv, fpm, pend, intr;
	int          miscompares = 0;
	int          n_checks = 0;
	int          ni, ns, ne, np_v;
	iit_ctrl_model u_ctl (.clk(mclk), .rst_b(rst_b), .start(ds));
	iit_top DUT (.MCLK(mclk), .RST_B(rst_b), .DS_START(ds), .NEXT_PARCEL(np),
		.HOLD_ISSUE(hold), .MONITOR_MODE(mon), .INT_COND(ic), .FP_RANGE_ERR(fe),
		.RUNNING(run), .PARCEL_ISSUE(iss), .INSTR_EXEC(ex), .PRIV_VIOLATION(pv),
		.FP_MODE(fpm), .INT_PEND(pend), .INTERRUPT(intr));
	initial forever #50 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %0t seen %0h exp %0h", $time, seen, exp);
		end
	endtask : chk
	// Outputs are sampled at the falling edge, where they have settled.
	task automatic watch(input int n, input bit stop);
		{ni, ns, ne, np_v} = '0;
		for (int i = 0; i < n; i++) begin
			@(negedge mclk);
			ni += (intr === 1'b1);
			ns += (iss === 1'b1);
			ne += (ex === 1'b1);
			np_v += (pv === 1'b1);
			if (stop && intr === 1'b1) break;
		end
	endtask : watch
	task automatic sense();
		ic = 1'b1;
		watch(1, 0);
		ic = 1'b0;
	endtask : sense
	task automatic t_count(input logic two);
		np = two ? 5'h18 : 5'h10;
		hold = 1'b1;
		sense();
		watch(6, 0);
		chk(ni, 0);
		chk(pend, 1);
		hold = 1'b0;
		watch(20, 1);
		chk(ns, two ? 3 : 2);
		chk(ni, 1);
		watch(3, 0);
		chk(pend, 0);
		$display("count test done");
	endtask : t_count
	task automatic t_deadstart();
		watch(2, 0);
		chk(run, 0);
		chk(ns, 0);
		watch(8, 0);
		chk(run, 1);
		chk(ns != 0, 1);
		$display("deadstart test done");
	endtask : t_deadstart
	task automatic t_first_int();
		sense();
		watch(3, 0);
		chk(ns, 3);
		chk(ni, 0);
		watch(12, 1);
		chk(ni, 1);
		$display("first interrupt test done");
	endtask : t_first_int
	task automatic t_two_cp();
		np = 5'h18;
		watch(8, 0);
		chk(ns, 8);
		chk(ne, 4);
		$display("two-parcel test done");
	endtask : t_two_cp
	task automatic t_monitor();
		mon = 1'b1;
		sense();
		watch(15, 0);
		chk(ni, 0);
		chk(pend, 0);
		mon = 1'b0;
		sense();
		watch(2, 0);
		chk(pend, 1);
		mon = 1'b1;
		watch(15, 0);
		chk(ni, 0);
		chk(pend, 0);
		mon = 1'b0;
		watch(12, 0);
		chk(ni, 0);
		$display("monitor test done");
	endtask : t_monitor
	task automatic t_float();
		np = 5'h12;
		watch(3, 0);
		chk(fpm, 0);
		np = 5'h10;
		fe = 1'b1;
		watch(1, 0);
		fe = 1'b0;
		watch(15, 0);
		chk(ni, 0);
		chk(pend, 0);
		np = 5'h14;
		watch(3, 0);
		chk(fpm, 1);
		np = 5'h10;
		mon = 1'b1;
		fe = 1'b1;
		watch(1, 0);
		fe = 1'b0;
		watch(15, 0);
		chk(ni, 0);
		mon = 1'b0;
		fe = 1'b1;
		watch(1, 0);
		fe = 1'b0;
		watch(15, 1);
		chk(ni, 1);
		$display("floating test done");
	endtask : t_float
	task automatic t_priv();
		np = 5'h11;
		watch(5, 0);
		chk(np_v, 5);
		chk(ne, 0);
		mon = 1'b1;
		watch(1, 0);
		watch(4, 0);
		chk(np_v, 0);
		chk(ne, 4);
		mon = 1'b0;
		$display("privilege test done");
	endtask : t_priv
	task automatic t_reset();
		np = 5'h12;
		watch(3, 0);
		rst_b = 1'b0;
		watch(1, 0);
		chk(run, 0);
		chk(fpm, 1);
		chk(pend, 0);
		rst_b = 1'b1;
		np = 5'h10;
		watch(2, 0);
		chk(run, 0);
		chk(ns, 0);
		watch(8, 0);
		chk(run, 1);
		$display("reset test done");
	endtask : t_reset
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(negedge mclk);
		rst_b = 1'b1;
		t_deadstart();
		t_first_int();
		t_count(1);
		t_count(0);
		t_two_cp();
		t_monitor();
		t_float();
		t_priv();
		t_reset();
		summarize();
	end
	// Whole run is a few hundred cycles; this bound is far beyond it.
	initial begin
		#400000;
		miscompares++;
		summarize();
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : summarize
endmodule : tb_iit_top
